// ### mastering_bus_port_signals.sv
`timescale 1ns/1ps
`include "bus_port_consts.svh"
// Summary of operation
// - address_strobe goes low only after cycle status and address are valid.
// - each mastered memory cycle ends by returning address_strobe high.
// - while owning the bus, mem_dir is high for a read and low for a write.
// - irq_out is asserted when any enabled status source is pending, never for masked ones.
// - bus_request is pulled low while the bus is wanted for a transfer.
// - bus_request is released to high impedance when not requesting.
// - grant_ack_out is asserted only after grant_in has been received.
// - grant_ack_out is asserted only after address_strobe has been seen deasserted.
// - in bus style 1 slave_ack_lo and slave_ack_hi acknowledge a finished register access.
// - grant acknowledge signalling can start only when bus_style_sel equals 1; a cycle already owned runs on if it changes.
// - grant_ack_out is driven low once ownership can be taken, making the device master.
// - grant_ack_out is asserted only after both slave acknowledges have been seen deasserted.
// - grant_ack_out is asserted only after no previous master has been seen holding grant_ack_out.
module mastering_bus_port_signals #(
	parameter int IRQ_W = `IRQ_SRC_W
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	// configuration
	input wire logic i_bus_style_sel,
	// internal transfer side
	input wire logic i_xfer_req,
	input wire logic i_xfer_read,
	input wire logic i_addr_valid,
	input wire logic i_cycle_end,
	output logic o_xfer_done,
	// arbitration pins
	input wire logic i_grant_in,
	output logic o_bus_request,
	output logic o_bus_request_oe_n,
	input wire logic i_grant_ack,
	output logic o_grant_ack,
	output logic o_grant_ack_oe_n,
	// master cycle pins
	input wire logic i_address_strobe,
	output logic o_address_strobe,
	output logic o_address_strobe_oe_n,
	output logic o_mem_dir,
	output logic o_mem_dir_oe_n,
	// register slave pins
	input wire logic i_slave_sel,
	input wire logic i_slave_dir,
	input wire logic i_reg_done,
	output logic o_reg_write,
	input wire logic i_slave_ack_lo,
	input wire logic i_slave_ack_hi,
	output logic o_slave_ack_lo,
	output logic o_slave_ack_hi,
	output logic o_slave_ack_oe_n,
	// interrupt
	input wire logic [IRQ_W-1:0] i_irq_status,
	input wire logic [IRQ_W-1:0] i_irq_mask,
	output logic o_irq_out_n,
	output logic o_irq_oe_n
);
	import bus_port_pkg::*;

	// refuse widths that the status and mask gating cannot serve
	if (IRQ_W < 1) begin : g_bad_width
		$error("IRQ_W must be at least 1");
	end

	master_state_e state_q, state_d;
	logic dir_q, dir_d;
	logic ack_q, ack_d;
	logic irq_q;
	logic done_q;

	// bus is free to take only when every previous owner has let go
	wire logic style_ok = (i_bus_style_sel == `STYLE_68K);
	wire logic bus_free = ~i_grant_in & i_address_strobe & i_slave_ack_lo & i_slave_ack_hi
		& i_grant_ack;
	wire logic owning = (state_d == ST_ACK) | (state_d == ST_STRB) | (state_d == ST_END);
	wire logic irq_pend = |(i_irq_status & i_irq_mask);

	// next state of the mastering sequence
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (i_xfer_req && style_ok) begin
					state_d = ST_REQ;
				end
			end
			ST_REQ: begin
				// grant and every earlier owner are judged at one and the same edge
				if (!style_ok) begin
					state_d = ST_IDLE;
				end else if (bus_free) begin
					state_d = ST_ACK;
				end
			end
			ST_ACK: begin
				// style is not rechecked once owned, so a started cycle always ends
				if (i_addr_valid) begin
					state_d = ST_STRB;
				end
			end
			ST_STRB: begin
				if (i_cycle_end) begin
					state_d = ST_END;
				end
			end
			ST_END: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// direction is frozen when ownership is taken
	assign dir_d = (state_q == ST_REQ) ? i_xfer_read : dir_q;
	// acknowledge holds until the host drops its select
	assign ack_d = i_slave_sel & style_ok & (ack_q | i_reg_done);
	assign o_reg_write = i_slave_sel & ~i_slave_dir;

	// sequence state and latched values
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
			dir_q <= 1'b1;
			ack_q <= 1'b0;
			irq_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			dir_q <= dir_d;
			ack_q <= ack_d;
			irq_q <= irq_pend;
			done_q <= (state_d == ST_END);
		end
	end

	// pin flops, derived from the next state so pins track state_q exactly
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_bus_request <= `PIN_IDLE;
			o_bus_request_oe_n <= `OE_OFF;
			o_grant_ack <= `PIN_IDLE;
			o_grant_ack_oe_n <= `OE_OFF;
			o_address_strobe <= `PIN_IDLE;
			o_address_strobe_oe_n <= `OE_OFF;
			o_mem_dir <= 1'b1;
			o_mem_dir_oe_n <= `OE_OFF;
		end else begin
			o_bus_request <= 1'b0;
			o_bus_request_oe_n <= (state_d == ST_REQ) ? `OE_ON : `OE_OFF;
			o_grant_ack <= 1'b0;
			o_grant_ack_oe_n <= owning ? `OE_ON : `OE_OFF;
			o_address_strobe <= (state_d != ST_STRB);
			o_address_strobe_oe_n <= owning ? `OE_ON : `OE_OFF;
			o_mem_dir <= dir_d;
			o_mem_dir_oe_n <= owning ? `OE_ON : `OE_OFF;
		end
	end

	// open collector interrupt: drive low only, float otherwise
	assign o_irq_out_n = 1'b0;
	assign o_irq_oe_n = ~irq_q;
	// both lanes acknowledge: the register port answers at full width
	assign o_slave_ack_lo = ~ack_q;
	assign o_slave_ack_hi = ~ack_q;
	assign o_slave_ack_oe_n = ~(i_slave_sel & style_ok);
	assign o_xfer_done = done_q;

	// pin checks, all on the bus clock and quiet during reset
	chk_strobe_valid: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_address_strobe) |-> $past(i_addr_valid) && !o_address_strobe_oe_n)
		else $error("address strobe fell without valid address");
	chk_strobe_end: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(state_q == ST_STRB && i_cycle_end) |=> o_address_strobe && !o_address_strobe_oe_n
		##1 o_address_strobe_oe_n)
		else $error("memory cycle not ended by strobe rising");
	// direction may change only at the edge that takes the bus
	chk_dir_hold: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_mem_dir_oe_n) |-> o_mem_dir == $past(i_xfer_read))
		else $error("mem_dir does not follow transfer direction");
	chk_dir_stable: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!o_mem_dir_oe_n && !$past(o_mem_dir_oe_n) |-> $stable(o_mem_dir))
		else $error("mem_dir changed during an owned cycle");
	chk_irq_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		##1 (!o_irq_oe_n == $past(irq_pend)))
		else $error("interrupt output disagrees with enabled status");
	chk_req_drive: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(state_q == ST_IDLE && i_xfer_req && style_ok) |=> !o_bus_request_oe_n && !o_bus_request)
		else $error("bus request not driven low");
	chk_req_float: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(state_q != ST_REQ) |-> o_bus_request_oe_n)
		else $error("bus request driven while not requesting");
	chk_ack_cond: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_grant_ack_oe_n) |-> !$past(i_grant_in) && $past(style_ok) && !o_grant_ack)
		else $error("grant acknowledge taken without a grant");
	chk_ack_strobe_idle: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_grant_ack_oe_n) |-> $past(i_address_strobe))
		else $error("grant acknowledge taken while address strobe busy");
	chk_ack_slave_idle: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_grant_ack_oe_n) |-> $past(i_slave_ack_lo) && $past(i_slave_ack_hi))
		else $error("grant acknowledge taken while a slave still answers");
	chk_ack_prev_owner: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$fell(o_grant_ack_oe_n) |-> $past(i_grant_ack))
		else $error("grant acknowledge taken while another master holds it");
	chk_style_gate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!style_ok |=> o_bus_request_oe_n && (o_grant_ack_oe_n || !$past(o_grant_ack_oe_n)))
		else $error("grant acknowledge started outside bus style 1");
	chk_float_idle: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(state_q == ST_IDLE || state_q == ST_REQ) |-> o_grant_ack_oe_n && o_address_strobe_oe_n
		&& o_mem_dir_oe_n)
		else $error("master pins driven without ownership");
	chk_slave_ack: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(i_slave_sel && style_ok && i_reg_done) |=> (!o_slave_ack_lo && !o_slave_ack_hi)
		or !i_slave_sel)
		else $error("register access not acknowledged");
	chk_slave_style: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!style_ok |-> o_slave_ack_oe_n ##1 (o_slave_ack_lo && o_slave_ack_hi))
		else $error("slave acknowledge given outside bus style 1");
	chk_done_pulse: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		o_xfer_done |-> o_address_strobe && !o_address_strobe_oe_n ##1 !o_xfer_done)
		else $error("transfer done not a single cycle at strobe end");
endmodule : mastering_bus_port_signals

// ### bus_port_consts.svh
`ifndef BUS_PORT_CONSTS_SVH
`define BUS_PORT_CONSTS_SVH
// bus style code that selects the 68000-style port
`define STYLE_68K 1'b1
// number of interrupt sources
`define IRQ_SRC_W 16
// reset levels of the active-low pins and their enables
`define PIN_IDLE 1'b1
`define OE_OFF 1'b1
`define OE_ON 1'b0
`endif

// ### bus_port_pkg.sv
package bus_port_pkg;
	// mastering sequence, gray coded from ST_IDLE to ST_END; the return from ST_END to ST_IDLE flips two bits
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ = 3'b001,
		ST_ACK = 3'b011,
		ST_STRB = 3'b010,
		ST_END = 3'b110
	} master_state_e;
endpackage : bus_port_pkg

// ### bus_arbiter_model.sv
`timescale 1ns/1ps
// arbiter stand-in: offers the grant only while a bus request is driven
module bus_arbiter_model (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_br_oe_n,
	input wire logic i_slow,
	output logic o_grant_in
);
	logic [1:0] wait_q;
	// slow mode holds the offer back, as a busy arbiter would
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wait_q <= 2'h0;
			o_grant_in <= 1'b1;
		end else begin
			wait_q <= i_br_oe_n ? 2'h0 : wait_q + 2'(wait_q != 2'h3);
			o_grant_in <= i_br_oe_n | (i_slow & (wait_q != 2'h3));
		end
	end
endmodule : bus_arbiter_model

// ### test_mastering_bus_port_signals.sv
`timescale 1ns/1ps
module test_mastering_bus_port_signals;
	logic i_mclk = 0, i_sys_rst = 1, i_bus_style_sel = 1, i_xfer_req = 0, i_xfer_read = 0;
	logic i_addr_valid = 0, i_cycle_end = 0, i_slave_sel = 0, i_slave_dir = 1, i_reg_done = 0;
	logic slow = 0, other_as = 1, other_ack = 1, other_gack = 1;
	logic [15:0] i_irq_status = 16'h0, i_irq_mask = 16'h0;
	logic i_grant_in, i_grant_ack, i_address_strobe, i_slave_ack_lo, i_slave_ack_hi;
	logic o_xfer_done, o_bus_request, o_bus_request_oe_n, o_grant_ack, o_grant_ack_oe_n;
	logic o_address_strobe, o_address_strobe_oe_n, o_mem_dir, o_mem_dir_oe_n, o_reg_write;
	logic o_slave_ack_lo, o_slave_ack_hi, o_slave_ack_oe_n, o_irq_out_n, o_irq_oe_n;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	// wired pins with pull-ups, another master may pull them low
	assign i_grant_ack = (o_grant_ack_oe_n ? 1'b1 : o_grant_ack) & other_gack;
	assign i_address_strobe = (o_address_strobe_oe_n ? 1'b1 : o_address_strobe) & other_as;
	assign i_slave_ack_lo = (o_slave_ack_oe_n ? 1'b1 : o_slave_ack_lo) & other_ack;
	assign i_slave_ack_hi = (o_slave_ack_oe_n ? 1'b1 : o_slave_ack_hi) & other_ack;
	always #5 i_mclk = ~i_mclk;
	mastering_bus_port_signals mastering_bus_port_signals_i (.i_mclk, .i_sys_rst,
		.i_bus_style_sel, .i_xfer_req, .i_xfer_read, .i_addr_valid, .i_cycle_end, .o_xfer_done,
		.i_grant_in, .o_bus_request, .o_bus_request_oe_n, .i_grant_ack, .o_grant_ack,
		.o_grant_ack_oe_n, .i_address_strobe, .o_address_strobe, .o_address_strobe_oe_n,
		.o_mem_dir, .o_mem_dir_oe_n, .i_slave_sel, .i_slave_dir, .i_reg_done, .o_reg_write,
		.i_slave_ack_lo, .i_slave_ack_hi, .o_slave_ack_lo, .o_slave_ack_hi, .o_slave_ack_oe_n,
		.i_irq_status, .i_irq_mask, .o_irq_out_n, .o_irq_oe_n);
	bus_arbiter_model bus_arbiter_model_i (.i_mclk, .i_sys_rst, .i_br_oe_n(o_bus_request_oe_n),
		.i_slow(slow), .o_grant_in(i_grant_in));
	task automatic chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t pin level %b, wanted %b", $time, got, exp);
		end
	endtask : chk
	task automatic print_verdict();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	// one mastered cycle; blk picks which wired pin another party still holds low
	task automatic do_xfer(input logic rd, input int blk);
		@(posedge i_mclk) {i_xfer_req, i_xfer_read} <= {1'b1, rd};
		{other_as, other_ack, other_gack} <= {blk != 1, blk != 2, blk != 3};
		@(posedge i_mclk) #1 chk(o_bus_request_oe_n, 1'b0);
		chk(o_bus_request, 1'b0);
		chk(o_grant_ack_oe_n, 1'b1);
		// without slow mode the grant reaches the port only one edge after the request shows
		@(posedge i_mclk);
		repeat (8) @(posedge i_mclk) #1 chk(o_grant_ack_oe_n, blk != 0);
		chk(o_address_strobe_oe_n, blk != 0);
		@(posedge i_mclk) {other_as, other_ack, other_gack} <= 3'h7;
		#1;
		for (int n = 0; n < 12 && o_grant_ack_oe_n !== 1'b0; n++) @(posedge i_mclk) #1;
		chk(o_grant_ack_oe_n, 1'b0);
		chk(o_grant_ack, 1'b0);
		chk(o_mem_dir_oe_n, 1'b0);
		chk(o_mem_dir, rd);
		chk(o_address_strobe, 1'b1);
		@(posedge i_mclk) i_addr_valid <= 1'b1;
		@(posedge i_mclk) #1 chk(o_address_strobe, 1'b0);
		@(posedge i_mclk) {i_addr_valid, i_cycle_end} <= 2'h1;
		@(posedge i_mclk) {i_xfer_req, i_cycle_end} <= 2'h0;
		#1 chk(o_address_strobe, 1'b1);
		chk(o_xfer_done, 1'b1);
		@(posedge i_mclk) #1 chk(o_grant_ack_oe_n & o_mem_dir_oe_n, 1'b1);
		chk(o_address_strobe_oe_n, 1'b1);
		chk(o_bus_request_oe_n, 1'b1);
	endtask : do_xfer
	task automatic test_blocked();
		slow <= 1'b1;
		for (int b = 1; b < 4; b++) do_xfer(1'b0, b);
		slow <= 1'b0;
	endtask : test_blocked
	task automatic test_slave(input logic sty);
		// outside style 1 the engine asks for the bus, which must be ignored
		@(posedge i_mclk) {i_bus_style_sel, i_xfer_req} <= {sty, ~sty};
		{i_slave_sel, i_slave_dir} <= 2'h2;
		#1 chk(o_reg_write, 1'b1);
		chk(o_slave_ack_oe_n, ~sty);
		@(posedge i_mclk) i_reg_done <= 1'b1;
		@(posedge i_mclk) i_reg_done <= 1'b0;
		#1 chk(o_slave_ack_lo | o_slave_ack_oe_n, ~sty);
		chk(o_slave_ack_hi | o_slave_ack_oe_n, ~sty);
		chk(o_bus_request_oe_n, 1'b1);
		chk(o_grant_ack_oe_n, 1'b1);
		@(posedge i_mclk) {i_slave_sel, i_xfer_req, i_bus_style_sel} <= 3'h1;
		#1 chk(o_slave_ack_oe_n, 1'b1);
	endtask : test_slave
	task automatic test_irq(input logic [15:0] st, input logic exp_n);
		@(posedge i_mclk) {i_irq_mask, i_irq_status} <= {16'h0001, st};
		repeat (2) @(posedge i_mclk);
		#1 chk(o_irq_oe_n, exp_n);
		chk(o_irq_out_n | o_irq_oe_n, exp_n);
	endtask : test_irq
	// run ceiling well above the fewer than one hundred cycles the tests take
	always @(posedge i_mclk) if (++cyc > 3000) begin
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		do_xfer(1'b1, 0);
		test_blocked();
		test_slave(1'b1);
		test_slave(1'b0);
		test_irq(16'h0002, 1'b1);
		test_irq(16'h0003, 1'b0);
		test_irq(16'h0000, 1'b1);
		print_verdict();
	end
endmodule : test_mastering_bus_port_signals
